// *** hdl/telem_map.svh ***
// constants for the telemetry and overvoltage-threshold responder
// assumes inclusion from the package and design files by bare name
`ifndef TELEM_MAP_SVH
`define TELEM_MAP_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_READ_DUTY   8'h94
`define CMD_READ_VOUT   8'h8b
`define CMD_READ_IOUT   8'h8c
`define CMD_READ_TEMP   8'h8d
`define CMD_OV_THRESH   8'hd5

// ----------------------------------------------------------------
// linear format fields and exponents
// ----------------------------------------------------------------
`define LIN_EXP_MSB     15
`define LIN_EXP_LSB     11
`define LIN_MANT_W      11
`define EXP_DUTY        5'h1e
`define EXP_UNITY       5'h00

// ----------------------------------------------------------------
// sections and overvoltage offsets
// ----------------------------------------------------------------
`define SECT_MULTI      1'b0
`define SECT_SINGLE     1'b1
`define VID_STEP_MV     5
`define OV_MV_SEL0      175
`define OV_MV_SEL1      225
`define OV_MV_SEL2      275
`define OV_MV_SEL3      325
`define OV_SEL_RESET    2'h0
`define OV_SEL_MAX      8'h03

`endif

// *** hdl/telem_pkg.sv ***
// types and shared arithmetic for the telemetry responder
// assumes telem_map.svh is on the include path
`include "telem_map.svh"

package telem_pkg;

  typedef logic [1:0]  ov_sel_t;
  typedef logic [15:0] word_t;

  // pack exponent and mantissa into one linear-format word
  function automatic word_t lin_pack(input logic [4:0]  e,
                                     input logic [10:0] m);
    return {e, m};
  endfunction

  // overvoltage offset in voltage-code steps for a selection
  function automatic logic [6:0] ov_steps(input ov_sel_t s);
    int mv;
    case (s)
      2'h0:    mv = `OV_MV_SEL0;
      2'h1:    mv = `OV_MV_SEL1;
      2'h2:    mv = `OV_MV_SEL2;
      default: mv = `OV_MV_SEL3;
    endcase
    return 7'(mv / `VID_STEP_MV);
  endfunction

endpackage

// *** hdl/ov_sel_if.sv ***
// carrier between the responder and the threshold store
// assumes both ends share core_clk
`timescale 1ns/1ps

interface ov_sel_if;
  logic                      wr_en;
  logic                      wr_sect;
  telem_pkg::ov_sel_t        wr_sel;
  telem_pkg::ov_sel_t [1:0]  sel;

  modport cfg   (output wr_en, output wr_sect, output wr_sel, input sel);
  modport store (input wr_en, input wr_sect, input wr_sel, output sel);
endinterface

// *** hdl/ov_thresh_store.sv ***
// per-section overvoltage threshold selections
// assumes writes arrive already range checked from the responder
`timescale 1ns/1ps
`include "telem_map.svh"

module ov_thresh_store (
  // clock and reset
  input wire logic  core_clk,
  input wire logic  rst,
  input wire logic  ce,
  // selection traffic
  ov_sel_if.store   ovs
);
  import telem_pkg::*;

  typedef struct packed {
    ov_sel_t [1:0] sel;
  } store_t;

  store_t s_q;
  store_t s_d;

  // each section keeps its own selection; a write touches only one
  always_comb begin
    s_d = s_q;
    if (ovs.wr_en) begin
      s_d.sel[ovs.wr_sect] = ovs.wr_sel;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q.sel <= {2{`OV_SEL_RESET}};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign ovs.sel = s_q.sel;

  a_sel_indep: assert property (@(posedge core_clk) disable iff (rst)
    ce && ovs.wr_en |=> ovs.sel[!$past(ovs.wr_sect)] ==
                        $past(ovs.sel[!ovs.wr_sect]))
    else $error("write to one section changed the other");

endmodule

// *** hdl/pmbus_telemetry_ov_config.sv ***
// telemetry and overvoltage-threshold responder behind the bus framer
// assumes the framer hands over decoded commands on core_clk, and that
// all telemetry inputs are produced by logic on the same clock
`timescale 1ns/1ps
`include "telem_map.svh"

module pmbus_telemetry_ov_config #(
  parameter int CODE_W = 8,
  parameter int MEAS_W = 8
) (
  // clock, reset, enable
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // decoded command from the framer
  input  wire logic                   cmd_valid,
  input  wire logic                   cmd_write,
  input  wire logic                   cmd_sect,
  input  wire logic [7:0]             cmd_code,
  input  wire logic [7:0]             cmd_data,
  // reply to the framer
  output logic                        rsp_valid,
  output logic                        rsp_err,
  output telem_pkg::word_t            rsp_data,
  // telemetry sources
  input  wire logic [8:0]             duty_quarter,
  input  wire logic [1:0][CODE_W-1:0] voltage_code,
  input  wire logic [1:0][MEAS_W-1:0] iout_amp,
  input  wire logic [MEAS_W-1:0]      temp_degc,
  // overvoltage limit per section, in voltage-code steps
  output logic [1:0][CODE_W:0]        ov_limit_code
);
  import telem_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the mantissa is 11 bits and the raw code must fit a word
  if (CODE_W < 7 || CODE_W > 15) begin : g_bad_code
    $error("CODE_W out of range");
  end
  if (MEAS_W < 1 || MEAS_W > 10) begin : g_bad_meas
    $error("MEAS_W must leave a zero sign bit in the mantissa");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   rsp_valid;
    logic                   rsp_err;
    word_t                  rsp_data;
    logic [1:0][CODE_W:0]   limit;
  } resp_t;

  resp_t s_q;
  resp_t s_d;

  ov_sel_if ovs ();

  ov_thresh_store u_store (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .ovs      (ovs.store)
  );

  logic take;
  assign take = cmd_valid;

  // ----------------------------------------------------------------
  // command decode and reply formation
  // ----------------------------------------------------------------
  // one command per cycle; the reply is a one-cycle pulse the cycle after
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    ovs.wr_en   = 1'b0;
    ovs.wr_sect = cmd_sect;
    ovs.wr_sel  = cmd_data[1:0];
    if (take) begin
      s_d.rsp_valid = 1'b1;
      s_d.rsp_err   = 1'b0;
      s_d.rsp_data  = '0;
      case (cmd_code)
        `CMD_READ_DUTY: begin
          // duty exists only for the multi-phase section
          if (cmd_write || cmd_sect != `SECT_MULTI) begin
            s_d.rsp_err = 1'b1;
          end else begin
            s_d.rsp_data = lin_pack(`EXP_DUTY,
                                    {2'b00, duty_quarter});
          end
        end
        `CMD_READ_VOUT: begin
          if (cmd_write) begin
            s_d.rsp_err = 1'b1;
          end else begin
            s_d.rsp_data = 16'(voltage_code[cmd_sect]);
          end
        end
        `CMD_READ_IOUT: begin
          if (cmd_write) begin
            s_d.rsp_err = 1'b1;
          end else begin
            s_d.rsp_data = lin_pack(`EXP_UNITY,
              11'(iout_amp[cmd_sect]));
          end
        end
        `CMD_READ_TEMP: begin
          // temperature is the multi-phase power stage whatever the page
          if (cmd_write) begin
            s_d.rsp_err = 1'b1;
          end else begin
            s_d.rsp_data = lin_pack(`EXP_UNITY,
                                    11'(temp_degc));
          end
        end
        `CMD_OV_THRESH: begin
          if (cmd_write) begin
            // bytes above 03h are refused and the old selection kept
            if (cmd_data > `OV_SEL_MAX) begin
              s_d.rsp_err = 1'b1;
            end else begin
              ovs.wr_en = 1'b1;
            end
          end else begin
            s_d.rsp_data = 16'(ovs.sel[cmd_sect]);
          end
        end
        default: begin
          s_d.rsp_err = 1'b1;
        end
      endcase
    end
    // limit tracks the live code; a selection write shows two cycles after the command
    for (int i = 0; i < 2; i++) begin
      s_d.limit[i] = (CODE_W+1)'(voltage_code[i]) +
                     (CODE_W+1)'(ov_steps(ovs.sel[i]));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rsp_valid     = s_q.rsp_valid;
  assign rsp_err       = s_q.rsp_err;
  assign rsp_data      = s_q.rsp_data;
  assign ov_limit_code = s_q.limit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_duty_reply: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && !cmd_write && cmd_sect == 1'b0 &&
    cmd_code == 8'h94 |=> rsp_valid && !rsp_err &&
    rsp_data == {5'h1e, 2'b00, $past(duty_quarter)})
    else $error("duty reply wrong");

  a_vout_reply: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && !cmd_write && cmd_code == 8'h8b
    |=> rsp_valid && rsp_data == 16'($past(voltage_code[cmd_sect])))
    else $error("voltage code reply wrong");

  a_iout_reply: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && !cmd_write && cmd_code == 8'h8c
    |=> rsp_valid && rsp_data[15:11] == 5'h00 &&
        rsp_data[10:0] == 11'($past(iout_amp[cmd_sect])))
    else $error("current reply wrong");

  a_temp_reply: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && !cmd_write && cmd_code == 8'h8d
    |=> rsp_valid && rsp_data == {5'h00, 11'($past(temp_degc))})
    else $error("temperature reply wrong");

  a_ov_default: assert property (@(posedge core_clk)
    $fell(rst) |-> ovs.sel == 4'h0)
    else $error("threshold not at +175 mV after reset");

  a_ov_limit: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> ov_limit_code[$past(cmd_sect)] ==
      (CODE_W+1)'($past(voltage_code[cmd_sect])) +
      (CODE_W+1)'(7'd35 + 7'd10 * 7'($past(ovs.sel[cmd_sect]))))
    else $error("section limit does not follow its selection");

  a_word_pulse: assert property (@(posedge core_clk) disable iff (rst)
    ce && !cmd_valid && rsp_valid |=> !rsp_valid)
    else $error("reply pulse held too long");

  a_lin_pack: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && !cmd_write && cmd_code == 8'h94 && cmd_sect == 1'b0
    |=> rsp_data[15:11] == 5'h1e && rsp_data[10:9] == 2'b00)
    else $error("exponent not in upper five bits");

  a_bad_refused: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && cmd_write && cmd_code == 8'hd5 && cmd_data > 8'h03
    |=> rsp_err && $stable(ovs.sel))
    else $error("out of range threshold accepted");

  a_store_write: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && cmd_write && cmd_code == 8'hd5 && cmd_data <= 8'h03
    |=> !rsp_err && ovs.sel[$past(cmd_sect)] == $past(cmd_data[1:0]))
    else $error("threshold write not stored");

  a_ro_write: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_valid && cmd_write && cmd_code != 8'hd5
    |=> rsp_valid && rsp_err && rsp_data == 16'h0000)
    else $error("write to a read-only code accepted");

  // a frozen enable must hold rsp_valid, rsp_data and the limits where they stand
  a_ce_freeze: assert property (@(posedge core_clk) disable iff (rst)
    !ce |=> $stable(rsp_valid) && $stable(rsp_data) &&
            $stable(ov_limit_code))
    else $error("state moved while the enable was low");

endmodule

// *** test/host_model.sv ***
// bus host side model: hands decoded commands to the responder
// assumes launches on the falling edge of core_clk
`timescale 1ns/1ps

module host_model (
  // clock
  input  wire logic       core_clk,
  // decoded command toward the responder
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic            cmd_sect,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_data
);
  // quiet lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sect  = 1'b0;
    cmd_code  = 8'h00;
    cmd_data  = 8'h00;
  end

  // one command per cycle; back to back calls keep valid high
  task automatic send(input logic w, input logic s,
                      input logic [7:0] c, input logic [7:0] d);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sect  = s;
    cmd_code  = c;
    cmd_data  = d;
  endtask

  // idle: flip the qualifiers so no stale value can pass for a command
  task automatic idle();
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_write = ~cmd_write;
    cmd_code  = ~cmd_code;
    cmd_data  = ~cmd_data;
  endtask
endmodule

// *** test/pmbus_telemetry_ov_config_test.sv ***
// self-checking bench for the telemetry and threshold responder
// assumes host_model drives commands; replies are checked from a queue
`timescale 1ns/1ps

`define EXPECT(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("BAD %0t got %h exp %h", $time, got, exp); end end

module pmbus_telemetry_ov_config_test;
  import telem_pkg::*;
  logic                core_clk;
  logic                rst;
  logic                ce;
  logic                cmd_valid;
  logic                cmd_write;
  logic                cmd_sect;
  logic [7:0]          cmd_code;
  logic [7:0]          cmd_data;
  logic                rsp_valid;
  logic                rsp_err;
  word_t               rsp_data;
  logic [8:0]          duty_quarter;
  logic [1:0][7:0]     voltage_code;
  logic [1:0][7:0]     iout_amp;
  logic [7:0]          temp_degc;
  logic [1:0][8:0]     ov_limit_code;
  logic [16:0]         exp_q[$];
  logic [16:0]         exp_note;
  logic [16:0]         got_note;
  ov_sel_t             ov_sel_exp [2];
  logic [15:0]         lfsr;
  int                  n_mismatch;
  int                  cmp_count;

  pmbus_telemetry_ov_config #(.CODE_W(8), .MEAS_W(8)) DUT (
    .core_clk(core_clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_sect(cmd_sect), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_data(rsp_data), .duty_quarter(duty_quarter),
    .voltage_code(voltage_code), .iout_amp(iout_amp),
    .temp_degc(temp_degc), .ov_limit_code(ov_limit_code));

  host_model host (
    .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sect(cmd_sect), .cmd_code(cmd_code), .cmd_data(cmd_data));

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // note the expected reply, then launch the command
  task automatic cmd(input logic w, input logic s, input logic [7:0] c,
                     input logic [7:0] d, input logic [16:0] e);
    exp_q.push_back(e);
    host.send(w, s, c, d);
  endtask

  // new telemetry only while no command is on the lines
  task automatic shuffle();
    host.idle();
    lfsr = lfsr_next(lfsr);
    duty_quarter = lfsr[8:0];
    voltage_code = {lfsr[7:0], lfsr[15:8]};
    lfsr = lfsr_next(lfsr);
    iout_amp = lfsr;
    temp_degc = lfsr[12:5];
  endtask

  // limits follow the code plus the selected offset in 5 mV steps
  task automatic check_limits();
    logic [8:0] want;
    host.idle();
    repeat (3) @(negedge core_clk);
    for (int s = 0; s < 2; s++) begin
      want = 9'(voltage_code[s]) + 9'((175 + 50 * ov_sel_exp[s]) / 5);
      `EXPECT(ov_limit_code[s], want)
    end
  endtask

  // reply watcher: every strobe takes the oldest note
  always @(posedge core_clk) begin
    #1;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("BAD %0t reply with nothing expected", $time);
      end else begin
        exp_note = exp_q.pop_front();
        got_note = {rsp_err, rsp_data};
        `EXPECT(got_note, exp_note)
      end
    end
  end

  // hang guard
  initial begin
    #200000;
    n_mismatch++;
    $display("BAD %0t run limit reached", $time);
    report_and_stop();
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    lfsr = 16'h0004;
    n_mismatch = 0;
    cmp_count = 0;
    ov_sel_exp = '{2'h0, 2'h0};
    duty_quarter = 9'h000;
    voltage_code = 16'h0000;
    iout_amp = 16'h0000;
    temp_degc = 8'h00;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    check_limits();
    // back to back reads of every telemetry kind plus refusals
    repeat (8) begin
      shuffle();
      cmd(0, 0, 8'h94, 8'h00, {1'b0, 5'h1e, 2'h0, duty_quarter});
      cmd(0, 0, 8'h8b, 8'h00, {9'h000, voltage_code[0]});
      cmd(0, 1, 8'h8b, 8'h00, {9'h000, voltage_code[1]});
      cmd(0, 0, 8'h8c, 8'h00, {9'h000, iout_amp[0]});
      cmd(0, 1, 8'h8c, 8'h00, {9'h000, iout_amp[1]});
      cmd(0, 0, 8'h8d, 8'h00, {9'h000, temp_degc});
      cmd(0, 1, 8'h94, 8'h00, 17'h10000);
      cmd(0, 0, 8'h00, 8'h00, 17'h10000);
      cmd(1, 0, 8'h8b, 8'h00, 17'h10000);
      check_limits();
    end
    // every selection in each section, the other section untouched
    for (int s = 0; s < 2; s++) begin
      for (int v = 0; v < 4; v++) begin
        cmd(1, s, 8'hd5, 8'(v), 17'h00000);
        ov_sel_exp[s] = 2'(v);
        cmd(0, s, 8'hd5, 8'h00, {15'h0000, 2'(v)});
        check_limits();
      end
    end
    // out of range bytes are refused and leave the selection alone
    cmd(1, 0, 8'hd5, 8'h04, 17'h10000);
    cmd(1, 1, 8'hd5, 8'hff, 17'h10000);
    check_limits();
    // enable low: a write on the lines is not taken, no reply appears
    ce = 1'b0;
    host.send(1, 0, 8'hd5, 8'h00);
    host.idle();
    ce = 1'b1;
    check_limits();
    // reset in mid-run brings both selections back to +175 mV
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    ov_sel_exp = '{2'h0, 2'h0};
    cmd(0, 1, 8'hd5, 8'h00, 17'h00000);
    check_limits();
    for (int i = 0; i < 50 && exp_q.size() > 0; i++)
      @(negedge core_clk);
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("BAD %0t replies missing", $time);
    end
    report_and_stop();
  end
endmodule
